// *** pjac_top.sv ***
// Jitter approach configuration registers with write checking.
// Assumes the approach sequencer drives the section and adjust strobes
// on the system clock.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// R1 - trigger count per step is code plus one
// R2 - period step 2(n+1), duty step n+1
// R3 - adjustment count is code plus one
// R4 - one adjustment updates count, step, dead-times (here count and step codes only)
// R5 - unimplemented control bits read as zero
// R6 - limit on: reject over-ceiling, set flag
// R7 - drift code changes count per section
// R8 - count saturates, frozen once target reached
module pjac_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Sequencer side
  input wire logic SEC_T2,
  input wire logic SEC_T3,
  input wire logic TARGET_REACHED,
  input wire logic ADJUST_STEP,
  output pjac_pkg::pjac_cfg_t APPROACH_CFG,
  output logic [2:0] CUR_TRIG_CODE,
  output logic ADJUST_LAST,
  // Interrupt
  output logic IRQ
);
  pjac_pkg::pjac_state_t s_r, s_nxt;
  logic [7:0] raddr;
  logic [31:0] rword;
  logic rhit;
  logic [15:0] val;
  logic over;
  logic [7:0] rej_set;
  logic wok;
  logic [7:0] set_b;

  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY = s_r.wready;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;
  assign IRQ = s_r.irq;
  assign CUR_TRIG_CODE = s_r.cur_cnt;
  assign ADJUST_LAST = s_r.adj_last;
  assign APPROACH_CFG = s_r.cfg;

  // Read decode
  always_comb begin
    raddr = S_AXI_ARADDR;
    rhit = 1'b1;
    rword = 32'h0000_0000;
    case (raddr)
      pjac_pkg::OFF_REJECT: rword = {24'h0, s_r.reject};
      pjac_pkg::OFF_TRIG_STEP:
        rword = {24'h0, s_r.trig_step & pjac_pkg::MASK_TRIG_STEP}; // see R5
      pjac_pkg::OFF_ADJ_DRIFT:
        rword = {24'h0, s_r.adj_drift & pjac_pkg::MASK_ADJ_DRIFT}; // see R5
      pjac_pkg::OFF_LIMIT: rword = {s_r.floor_dt, s_r.ceiling};
      pjac_pkg::OFF_WR_VALUE: rword = {s_r.tgt_a, s_r.period};
      pjac_pkg::OFF_IRQ_STAT: rword = {30'h0, s_r.irq_stat};
      pjac_pkg::OFF_IRQ_MASK: rword = {30'h0, s_r.irq_mask};
      default: rhit = 1'b0;
    endcase
  end

  // Value write check against ceiling and dead-time floor
  always_comb begin
    val = s_r.wdata[15:0];
    over = val > s_r.ceiling;
    rej_set = 8'h00;
    wok = 1'b1;
    case (s_r.wdata[18:16])
      pjac_pkg::TGT_PERIOD: rej_set[pjac_pkg::BIT_P] = over; // see R6
      pjac_pkg::TGT_A: rej_set[pjac_pkg::BIT_A] = over; // see R6
      pjac_pkg::TGT_B: rej_set[pjac_pkg::BIT_B] = over; // see R6
      pjac_pkg::TGT_HOLD: rej_set[pjac_pkg::BIT_H] = over; // see R6
      pjac_pkg::TGT_DT_A: rej_set[pjac_pkg::BIT_DTA] = val < s_r.floor_dt;
      pjac_pkg::TGT_DT_B: rej_set[pjac_pkg::BIT_DTB] = val < s_r.floor_dt;
      default: wok = 1'b0;
    endcase
    // Dead-time floor is checked always, the ceiling only when limiting
    if (!s_r.limit_en) begin
      rej_set = rej_set & 8'h03; // see R6
    end
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    set_b = 8'h00;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_nxt.waddr = S_AXI_AWADDR;
      s_nxt.waddr_ok = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wdata_ok = 1'b1;
    end
    case (s_r.wst)
      pjac_pkg::WR_IDLE: begin
        if (s_r.waddr_ok && s_r.wdata_ok) begin
          s_nxt.wst = pjac_pkg::WR_RESP;
        end
      end
      pjac_pkg::WR_RESP: begin
        s_nxt.bresp = pjac_pkg::RESP_OKAY;
        case (s_r.waddr)
          pjac_pkg::OFF_TRIG_STEP: begin
            s_nxt.trig_step = s_r.wdata[7:0] & pjac_pkg::MASK_TRIG_STEP;
          end
          pjac_pkg::OFF_ADJ_DRIFT: begin
            s_nxt.adj_drift = s_r.wdata[7:0] & pjac_pkg::MASK_ADJ_DRIFT;
            s_nxt.adj_done = 4'h0;
          end
          pjac_pkg::OFF_LIMIT: begin
            s_nxt.ceiling = s_r.wdata[15:0];
            s_nxt.floor_dt = {1'b0, s_r.wdata[30:16]};
            s_nxt.limit_en = s_r.wdata[31];
          end
          pjac_pkg::OFF_WR_VALUE: begin
            if (!wok) begin
              s_nxt.bresp = pjac_pkg::RESP_SLVERR;
            end else if (rej_set == 8'h00) begin
              case (s_r.wdata[18:16])
                pjac_pkg::TGT_PERIOD: s_nxt.period = val;
                pjac_pkg::TGT_A: s_nxt.tgt_a = val;
                pjac_pkg::TGT_B: s_nxt.tgt_b = val;
                pjac_pkg::TGT_HOLD: s_nxt.hold = val;
                pjac_pkg::TGT_DT_A: s_nxt.dt_a = val;
                default: s_nxt.dt_b = val;
              endcase
            end
            // Flag follows the latest write to its own register
            case (s_r.wdata[18:16])
              pjac_pkg::TGT_PERIOD: s_nxt.reject[pjac_pkg::BIT_P] =
                rej_set[pjac_pkg::BIT_P]; // see R6
              pjac_pkg::TGT_A: s_nxt.reject[pjac_pkg::BIT_A] =
                rej_set[pjac_pkg::BIT_A];
              pjac_pkg::TGT_B: s_nxt.reject[pjac_pkg::BIT_B] =
                rej_set[pjac_pkg::BIT_B];
              pjac_pkg::TGT_HOLD: s_nxt.reject[pjac_pkg::BIT_H] =
                rej_set[pjac_pkg::BIT_H];
              pjac_pkg::TGT_DT_A: s_nxt.reject[pjac_pkg::BIT_DTA] =
                rej_set[pjac_pkg::BIT_DTA];
              pjac_pkg::TGT_DT_B: s_nxt.reject[pjac_pkg::BIT_DTB] =
                rej_set[pjac_pkg::BIT_DTB];
              default: s_nxt.reject = s_r.reject;
            endcase
            set_b[0] = rej_set != 8'h00;
          end
          pjac_pkg::OFF_IRQ_STAT: begin
            s_nxt.irq_stat = s_r.irq_stat & ~s_r.wdata[1:0];
          end
          pjac_pkg::OFF_IRQ_MASK: s_nxt.irq_mask = s_r.wdata[1:0];
          pjac_pkg::OFF_REJECT: s_nxt.bresp = pjac_pkg::RESP_OKAY;
          default: s_nxt.bresp = pjac_pkg::RESP_SLVERR;
        endcase
        s_nxt.bvalid = 1'b1;
        s_nxt.waddr_ok = 1'b0;
        s_nxt.wdata_ok = 1'b0;
        s_nxt.wst = pjac_pkg::WR_HOLD;
      end
      pjac_pkg::WR_HOLD: begin
        if (S_AXI_BREADY) begin
          s_nxt.bvalid = 1'b0;
          s_nxt.wst = pjac_pkg::WR_IDLE;
        end
      end
      default: s_nxt.wst = pjac_pkg::WR_IDLE;
    endcase
    // Read channel
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rword;
      s_nxt.rresp = rhit ? pjac_pkg::RESP_OKAY : pjac_pkg::RESP_SLVERR;
    end else if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    // Working trigger and step codes with section drift
    if (ADJUST_STEP) begin // see R4
      s_nxt.cur_cnt = s_r.trig_step[6:4];
      s_nxt.cur_sa = s_r.trig_step[2:0];
      if (s_r.adj_done != 4'hF) begin
        s_nxt.adj_done = s_r.adj_done + 4'h1;
      end
      set_b[1] = ADJUST_LAST;
    end else if (!TARGET_REACHED && (SEC_T2 || SEC_T3)) begin // see R8
      if ((s_r.adj_drift[3:2] == pjac_pkg::DRIFT_UP_DOWN) == SEC_T2) begin
        if (s_r.adj_drift[3] && s_r.cur_cnt != 3'h7) begin // see R7
          s_nxt.cur_cnt = s_r.cur_cnt + 3'h1;
        end
      end else if (s_r.adj_drift[3] && s_r.cur_cnt != 3'h0) begin
        s_nxt.cur_cnt = s_r.cur_cnt - 3'h1; // see R8
      end
      if ((s_r.adj_drift[1:0] == pjac_pkg::DRIFT_UP_DOWN) == SEC_T2) begin
        if (s_r.adj_drift[1] && s_r.cur_sa != 3'h7) begin
          s_nxt.cur_sa = s_r.cur_sa + 3'h1;
        end
      end else if (s_r.adj_drift[1] && s_r.cur_sa != 3'h0) begin
        s_nxt.cur_sa = s_r.cur_sa - 3'h1;
      end
    end
    // Sticky events: set wins over the clear
    s_nxt.irq_stat = s_nxt.irq_stat | set_b[1:0];
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    // Registered outputs, decoded from the next working codes
    s_nxt.cfg.trig_per_step = {1'b0, s_nxt.cur_cnt} + 4'h1; // see R1
    s_nxt.cfg.period_step = {1'b0, s_nxt.cur_sa, 1'b0} + 5'h2; // see R2
    s_nxt.cfg.duty_step = {1'b0, s_nxt.cur_sa} + 4'h1; // see R2
    s_nxt.cfg.adjust_total = {1'b0, s_nxt.adj_drift[6:4]} + 4'h1; // see R3
    s_nxt.adj_last = s_nxt.adj_done == {1'b0, s_nxt.adj_drift[6:4]};
    s_nxt.awready = !s_nxt.waddr_ok && s_nxt.wst == pjac_pkg::WR_IDLE;
    s_nxt.wready = !s_nxt.wdata_ok && s_nxt.wst == pjac_pkg::WR_IDLE;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.wst <= pjac_pkg::WR_IDLE;
      s_r.cfg <= pjac_pkg::RST_CFG;
      s_r.adj_last <= 1'b1;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Assertions run on the system clock and rest during reset
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_reject_flag: assert property ( // see R6
    s_r.wst == pjac_pkg::WR_RESP && s_r.waddr == pjac_pkg::OFF_WR_VALUE &&
    s_r.wdata[18:16] == pjac_pkg::TGT_PERIOD && !s_r.limit_en
    |=> !s_r.reject[pjac_pkg::BIT_P] && s_r.period == $past(val))
    else $error("period write not accepted with limiting off");
  a_reject_over: assert property ( // see R6
    s_r.wst == pjac_pkg::WR_RESP && s_r.waddr == pjac_pkg::OFF_WR_VALUE &&
    s_r.wdata[18:16] == pjac_pkg::TGT_A && s_r.limit_en && over
    |=> s_r.reject[pjac_pkg::BIT_A] && $stable(s_r.tgt_a))
    else $error("over-ceiling target write not rejected");
  a_trig_decode: assert property ( // see R1
    APPROACH_CFG.trig_per_step == {1'b0, s_r.cur_cnt} + 4'h1)
    else $error("trigger count decode wrong");
  a_step_decode: assert property ( // see R2
    APPROACH_CFG.period_step == {APPROACH_CFG.duty_step, 1'b0})
    else $error("period step not twice duty step");
  a_adjust_total: assert property ( // see R3
    APPROACH_CFG.adjust_total > 4'h0 && APPROACH_CFG.adjust_total < 4'h9)
    else $error("adjustment total out of range");
  a_adjust_load: assert property ( // see R4
    ADJUST_STEP |=> s_r.cur_cnt == $past(s_r.trig_step[6:4]) &&
    s_r.cur_sa == $past(s_r.trig_step[2:0]))
    else $error("adjustment did not load codes");
  a_ctrl_zero: assert property ( // see R5
    s_r.rvalid |-> !(s_r.rdata[7] && $past(raddr) != pjac_pkg::OFF_REJECT
    && $past(raddr) != pjac_pkg::OFF_LIMIT
    && $past(raddr) != pjac_pkg::OFF_WR_VALUE))
    else $error("unimplemented bit read as one");
  a_count_frozen: assert property ( // see R8
    TARGET_REACHED && !ADJUST_STEP |=> $stable(s_r.cur_cnt))
    else $error("trigger count moved after target");
  a_drift_up: assert property ( // see R7
    SEC_T2 && !SEC_T3 && !ADJUST_STEP && !TARGET_REACHED &&
    s_r.adj_drift[3:2] == pjac_pkg::DRIFT_UP_DOWN && s_r.cur_cnt != 3'h7
    |=> s_r.cur_cnt == $past(s_r.cur_cnt) + 3'h1)
    else $error("drift did not add one in second section");
  c_write_rej: cover property (@(posedge CLK_SYS) s_r.reject != 8'h00);
  c_irq: cover property (@(posedge CLK_SYS) s_r.irq);
  c_drift: cover property (@(posedge CLK_SYS) SEC_T3 && s_r.adj_drift[3]);
endmodule : pjac_top

// *** pjac_pkg.sv ***
// Package for the jitter approach configuration block.
// Assumes a 32-bit AXI4-Lite master and a single 100 MHz system clock.
package pjac_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REJECT = 8'h00;
  localparam logic [7:0] OFF_TRIG_STEP = 8'h04;
  localparam logic [7:0] OFF_ADJ_DRIFT = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_WR_VALUE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Value write targets, selected by bits 18:16 of the value write
  localparam logic [2:0] TGT_PERIOD = 3'h0;
  localparam logic [2:0] TGT_A = 3'h1;
  localparam logic [2:0] TGT_B = 3'h2;
  localparam logic [2:0] TGT_HOLD = 3'h3;
  localparam logic [2:0] TGT_DT_A = 3'h4;
  localparam logic [2:0] TGT_DT_B = 3'h5;
  // Reject flag bit positions
  localparam int BIT_A = 7;
  localparam int BIT_B = 6;
  localparam int BIT_H = 5;
  localparam int BIT_P = 4;
  localparam int BIT_DTB = 1;
  localparam int BIT_DTA = 0;
  // Implemented bits of three registers, and reset constants
  localparam logic [7:0] MASK_REJECT = 8'hF3;
  localparam logic [7:0] MASK_TRIG_STEP = 8'h77;
  localparam logic [7:0] MASK_ADJ_DRIFT = 8'h7F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Drift codes and bus response codes
  localparam logic [1:0] DRIFT_UP_DOWN = 2'h2;
  localparam logic [1:0] DRIFT_DOWN_UP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded approach settings handed to the sequencer
  typedef struct packed {
    logic [3:0] trig_per_step;
    logic [4:0] period_step;
    logic [3:0] duty_step;
    logic [3:0] adjust_total;
  } pjac_cfg_t;

  // Settings shown after reset: every working code is zero
  localparam pjac_cfg_t RST_CFG = '{4'h1, 5'h02, 4'h1, 4'h1};

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } pjac_wst_t;

  typedef struct packed {
    pjac_wst_t wst;
    logic [7:0] waddr;
    logic waddr_ok;
    logic [31:0] wdata;
    logic wdata_ok;
    logic [1:0] bresp;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] reject;
    logic [7:0] trig_step;
    logic [7:0] adj_drift;
    logic limit_en;
    logic [15:0] ceiling;
    logic [15:0] floor_dt;
    logic [15:0] period;
    logic [15:0] tgt_a;
    logic [15:0] tgt_b;
    logic [15:0] hold;
    logic [15:0] dt_a;
    logic [15:0] dt_b;
    logic [2:0] cur_cnt;
    logic [2:0] cur_sa;
    logic [3:0] adj_done;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    pjac_cfg_t cfg;
    logic adj_last;
    logic awready;
    logic wready;
    logic arready;
  } pjac_state_t;
endpackage : pjac_pkg

// *** tb_pjac_top.sv ***
// Self-checking testbench for the jitter approach configuration block.
// Assumes pjac_pkg and pjac_top are compiled first; the bench is the bus
// master and the sequencer, and interrupt mask bits enable when set.
`timescale 1ns/1ps
module tb_pjac_top;
  // One ordinary case: control bytes written and the settings they give
  typedef struct packed {
    logic [7:0] ts;
    logic [7:0] ad;
    pjac_pkg::pjac_cfg_t cfg;
  } pjac_row_t;
  localparam pjac_row_t ROWS [8] = '{
    '{8'h8F, 8'h80, '{4'h1, 5'h10, 4'h8, 4'h1}},
    '{8'h9E, 8'h90, '{4'h2, 5'h0E, 4'h7, 4'h2}},
    '{8'hAD, 8'hA0, '{4'h3, 5'h0C, 4'h6, 4'h3}},
    '{8'hBC, 8'hB0, '{4'h4, 5'h0A, 4'h5, 4'h4}},
    '{8'hCB, 8'hC0, '{4'h5, 5'h08, 4'h4, 4'h5}},
    '{8'hDA, 8'hD0, '{4'h6, 5'h06, 4'h3, 4'h6}},
    '{8'hE9, 8'hE0, '{4'h7, 5'h04, 4'h2, 4'h7}},
    '{8'hF8, 8'hF0, '{4'h8, 5'h02, 4'h1, 4'h8}}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic sec_t2 = 1'b0, sec_t3 = 1'b0, tgt_hit = 1'b0, adj_step = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, adj_last, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [2:0] cur_code;
  pjac_pkg::pjac_cfg_t cfg;
  int n_errors = 0;
  int n_compared = 0;

  pjac_top i_dut (
    .CLK_SYS(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SEC_T2(sec_t2), .SEC_T3(sec_t3), .TARGET_REACHED(tgt_hit),
    .ADJUST_STEP(adj_step), .APPROACH_CFG(cfg), .CUR_TRIG_CODE(cur_code),
    .ADJUST_LAST(adj_last), .IRQ(irq));

  // System clock, 10 ns period
  initial forever #5 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus write: address and data offered together, response kept in resp
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 50) n_errors++;
  endtask : axw

  // Bus read: data in rd, response in resp
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 50) n_errors++;
  endtask : axr

  // One-cycle sequencer strobe {adjust, t2, t3}, then let it settle
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    {adj_step, sec_t2, sec_t3} <= p;
    @(posedge clk);
    {adj_step, sec_t2, sec_t3} <= 3'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog against a hung handshake
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      axr(8'(4 * i));
      chk(rd, 32'h0);
    end
    // Table of ordinary cases
    foreach (ROWS[i]) begin
      axw(pjac_pkg::OFF_TRIG_STEP, {24'h0, ROWS[i].ts});
      axw(pjac_pkg::OFF_ADJ_DRIFT, {24'h0, ROWS[i].ad});
      // Settings follow the working codes, loaded by an adjustment
      pulse(3'b100);
      axr(pjac_pkg::OFF_TRIG_STEP);
      chk(rd, {24'h0, ROWS[i].ts & 8'h77});
      axr(pjac_pkg::OFF_ADJ_DRIFT);
      chk(rd, {24'h0, ROWS[i].ad & 8'h7F});
      chk(32'(cfg.trig_per_step), 32'(ROWS[i].cfg.trig_per_step));
      chk(32'(cfg.period_step), 32'(ROWS[i].cfg.period_step));
      chk(32'(cfg.duty_step), 32'(ROWS[i].cfg.duty_step));
      chk(32'(cfg.adjust_total), 32'(ROWS[i].cfg.adjust_total));
    end
    // Ceiling on at 0x0100, dead-time floor 0x0010
    axw(pjac_pkg::OFF_LIMIT, 32'h8010_0100);
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0000_0200);
    axr(pjac_pkg::OFF_REJECT);
    chk(rd, 32'h10);
    axr(pjac_pkg::OFF_IRQ_STAT);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    axw(pjac_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    axw(pjac_pkg::OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0);
    // Value equal to the ceiling passes and clears the flag
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0000_0100);
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0001_0101);
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0004_0008);
    axr(pjac_pkg::OFF_REJECT);
    chk(rd, 32'h81);
    axr(pjac_pkg::OFF_WR_VALUE);
    chk(rd, 32'h0000_0100);
    // Ceiling off: a value above the ceiling is taken
    axw(pjac_pkg::OFF_LIMIT, 32'h0010_0000);
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0001_FFFF);
    axr(pjac_pkg::OFF_WR_VALUE);
    chk(rd, 32'hFFFF_0100);
    axw(pjac_pkg::OFF_REJECT, 32'hFF);
    axr(pjac_pkg::OFF_REJECT);
    chk(rd, 32'h01);
    // Bad value target and unmapped read
    axw(pjac_pkg::OFF_WR_VALUE, 32'h0006_0000);
    chk(32'(resp), 32'(pjac_pkg::RESP_SLVERR));
    axr(8'h1C);
    chk({rd[29:0], resp}, {30'h0, pjac_pkg::RESP_SLVERR});
    // Drift code 10 from trigger code 6, saturation and freeze
    axw(pjac_pkg::OFF_TRIG_STEP, 32'h60);
    axw(pjac_pkg::OFF_ADJ_DRIFT, 32'h08);
    pulse(3'b100);
    chk(32'(cur_code), 32'h6);
    pulse(3'b010);
    chk(32'(cur_code), 32'h7);
    pulse(3'b010);
    chk(32'(cur_code), 32'h7);
    pulse(3'b001);
    chk(32'(cur_code), 32'h6);
    tgt_hit <= 1'b1;
    pulse(3'b001);
    chk(32'(cur_code), 32'h6);
    tgt_hit <= 1'b0;
    // Drift code 11 reverses, and the floor holds at 000
    axw(pjac_pkg::OFF_ADJ_DRIFT, 32'h0C);
    pulse(3'b010);
    chk(32'(cur_code), 32'h5);
    pulse(3'b001);
    chk(32'(cur_code), 32'h6);
    axw(pjac_pkg::OFF_TRIG_STEP, 32'h00);
    pulse(3'b100);
    pulse(3'b010);
    chk(32'(cur_code), 32'h0);
    // Two adjustments: the last one is flagged and sets status bit 1
    axw(pjac_pkg::OFF_IRQ_STAT, 32'h3);
    axw(pjac_pkg::OFF_ADJ_DRIFT, 32'h10);
    chk(32'(adj_last), 32'h0);
    pulse(3'b100);
    chk(32'(adj_last), 32'h1);
    pulse(3'b100);
    chk(32'(adj_last), 32'h0);
    axr(pjac_pkg::OFF_IRQ_STAT);
    chk(rd, 32'h2);
    stop_test();
  end
endmodule : tb_pjac_top
